// ### rtl/load_store_isa_options.sv
// Purpose: Execute-stage option unit: memory request shaping, DSP arithmetic, traps.
// Assumes: Operands arrive decoded and valid for one cycle with op_valid_in.
// Notes: Results appear registered one cycle after the request; base writeback appears two cycles after.
`timescale 1ns/1ps
module load_store_isa_options (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // Decoded operation
    input wire logic op_valid_in,
    input wire logic [4:0] op_code_in,
    input wire logic isa16_in,
    input wire logic [3:0] cp_num_in,
    input wire logic x_top_in,
    input wire logic y_top_in,
    input wire logic writeback_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] base_next_in,
    input wire logic [31:0] opa_in,
    input wire logic [31:0] opb_in,
    input wire logic [63:0] acc_in,
    // System control state
    input wire logic [31:0] ctrl_reg_in,
    input wire logic [31:0] cp_access_in,
    input wire logic mmu_on_in,
    // Memory side feedback
    input wire logic page_cacheable_in,
    input wire logic line_resident_in,
    input wire logic data_abort_in,
    // Memory request
    output logic mem_req_out,
    output logic mem_read_out,
    output logic mem_big_endian_out,
    output logic [31:0] mem_addr_out,
    output logic mmu_check_out,
    output logic dbg_watch_out,
    // Results
    output logic [63:0] result_out,
    output logic result_valid_out,
    output logic q_flag_out,
    output logic base_we_out,
    output logic [31:0] base_out,
    output logic undef_out,
    output logic align_fault_out,
    output logic [39:0] dsp_acc_out,
    output logic isa16_ok_out
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEM = 2'b01
    } st_e;

    st_e st_reg;
    logic [31:0] base_hold_reg;
    logic wb_hold_reg;
    logic [39:0] acc_reg;
    lsopt_pkg::op_e op;
    logic is_mem, is_dw, dw_bad, is_cpd, cp_bad, dsp_off, undef_now, preload_skip;
    logic [63:0] res_next;
    logic q_next;

    assign op = lsopt_pkg::op_e'(op_code_in);
    assign is_dw = (op == lsopt_pkg::OP_LOAD_DWORD) || (op == lsopt_pkg::OP_STORE_DWORD);
    assign dw_bad = is_dw && (addr_in[2:0] == lsopt_pkg::DWORD_BAD_LOW);
    assign is_cpd = (op == lsopt_pkg::OP_CP_DWRITE) || (op == lsopt_pkg::OP_CP_DREAD);
    assign cp_bad = is_cpd && (cp_num_in != lsopt_pkg::DSP_CP_NUM);
    assign dsp_off = is_cpd && !cp_access_in[lsopt_pkg::CPACC_DSP_BIT];
    // 26-bit mode requests are never honoured.
    assign undef_now = cp_bad || dsp_off || (op == lsopt_pkg::OP_MODE26);
    assign preload_skip = !page_cacheable_in || line_resident_in;
    assign is_mem = (op == lsopt_pkg::OP_LOAD) || (op == lsopt_pkg::OP_STORE) ||
                    (is_dw && !dw_bad) ||
                    ((op == lsopt_pkg::OP_PRELOAD) && !preload_skip);

    function automatic logic [5:0] lead_zeros(input logic [31:0] v);
        logic [5:0] n;
        logic found;
        n = 6'h20;
        found = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (!found && v[i]) begin
                n = 6'(31 - i);
                found = 1'b1;
            end
        end
        return n;
    endfunction

    function automatic logic [32:0] sat_add(input logic [31:0] a, input logic [31:0] b,
                                             input logic sub);
        logic [32:0] s;
        logic ovf;
        s = sub ? ({a[31], a} - {b[31], b}) : ({a[31], a} + {b[31], b});
        ovf = s[32] != s[31];
        if (ovf) begin
            return {1'b1, s[32] ? lsopt_pkg::SAT_MIN : lsopt_pkg::SAT_MAX};
        end
        return {1'b0, s[31:0]};
    endfunction

    // Arithmetic result and saturation flag.
    always_comb begin
        logic [15:0] xh, yh;
        logic [31:0] p16;
        logic [47:0] p48;
        logic [32:0] d, r;
        xh = x_top_in ? opa_in[31:16] : opa_in[15:0];
        yh = y_top_in ? opb_in[31:16] : opb_in[15:0];
        p16 = 32'($signed(xh) * $signed(yh));
        p48 = 48'($signed(opa_in) * $signed(yh));
        d = 33'h0;
        r = 33'h0;
        res_next = 64'h0;
        q_next = 1'b0;
        case (op)
            lsopt_pkg::OP_LEAD_ZEROS: res_next = {58'h0, lead_zeros(opa_in)};
            lsopt_pkg::OP_SAT_ADD, lsopt_pkg::OP_SAT_SUB: begin
                r = sat_add(opa_in, opb_in, op == lsopt_pkg::OP_SAT_SUB);
                res_next = {32'h0, r[31:0]};
                q_next = r[32];
            end
            lsopt_pkg::OP_DBL_SAT_ADD, lsopt_pkg::OP_DBL_SAT_SUB: begin
                d = sat_add(opb_in, opb_in, 1'b0);
                r = sat_add(opa_in, d[31:0], op == lsopt_pkg::OP_DBL_SAT_SUB);
                res_next = {32'h0, r[31:0]};
                q_next = r[32] | d[32];
            end
            lsopt_pkg::OP_HMUL: res_next = {32'h0, p16};
            lsopt_pkg::OP_HMAC32: begin
                r = sat_add(p16, acc_in[31:0], 1'b0);
                res_next = {32'h0, p16 + acc_in[31:0]};
                q_next = r[32];
            end
            lsopt_pkg::OP_HMAC64: res_next = acc_in + {{32{p16[31]}}, p16};
            lsopt_pkg::OP_WHMUL: res_next = {32'h0, p48[47:16]};
            lsopt_pkg::OP_WHMAC: begin
                r = sat_add(p48[47:16], acc_in[31:0], 1'b0);
                res_next = {32'h0, p48[47:16] + acc_in[31:0]};
                q_next = r[32];
            end
            lsopt_pkg::OP_CP_DREAD: res_next = {{24{acc_reg[39]}}, acc_reg};
            default: res_next = 64'h0;
        endcase
    end

    // Memory request shaping.
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            mem_req_out <= 1'b0;
            mem_read_out <= 1'b0;
            mem_addr_out <= 32'h0;
            mmu_check_out <= 1'b0;
            dbg_watch_out <= 1'b0;
            mem_big_endian_out <= 1'b0;
        end else begin
            // Endian applies with or without translation, so mmu_on_in is not consulted.
            mem_big_endian_out <= ctrl_reg_in[lsopt_pkg::CTRL_ENDIAN_BIT];
            mem_req_out <= op_valid_in && is_mem && !undef_now;
            mem_read_out <= op_valid_in && (op != lsopt_pkg::OP_STORE) &&
                            (op != lsopt_pkg::OP_STORE_DWORD);
            mem_addr_out <= addr_in;
            mmu_check_out <= op_valid_in && (is_mem || op == lsopt_pkg::OP_PRELOAD);
            dbg_watch_out <= op_valid_in && is_mem && (op != lsopt_pkg::OP_PRELOAD);
        end
    end

    // Results, traps and the wide accumulator.
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            result_out <= 64'h0;
            result_valid_out <= 1'b0;
            q_flag_out <= 1'b0;
            undef_out <= 1'b0;
            align_fault_out <= 1'b0;
            acc_reg <= 40'h0;
            dsp_acc_out <= 40'h0;
            isa16_ok_out <= 1'b0;
        end else begin
            isa16_ok_out <= isa16_in;
            undef_out <= op_valid_in && undef_now;
            align_fault_out <= op_valid_in && dw_bad;
            result_valid_out <= op_valid_in && !undef_now && !is_mem && !dw_bad;
            result_out <= res_next;
            q_flag_out <= op_valid_in && q_next;
            if (op_valid_in && (op == lsopt_pkg::OP_CP_DWRITE) && !undef_now) begin
                acc_reg <= {acc_in[39:32], acc_in[31:0]};
                dsp_acc_out <= {acc_in[39:32], acc_in[31:0]};
            end
        end
    end

    // Base writeback is held until the access completes without abort.
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st_reg <= ST_IDLE;
            base_hold_reg <= 32'h0;
            wb_hold_reg <= 1'b0;
            base_we_out <= 1'b0;
            base_out <= 32'h0;
        end else begin
            base_we_out <= 1'b0;
            case (st_reg)
                ST_IDLE: begin
                    if (op_valid_in && is_mem && !undef_now &&
                        op != lsopt_pkg::OP_PRELOAD) begin
                        st_reg <= ST_MEM;
                        base_hold_reg <= base_next_in;
                        wb_hold_reg <= writeback_in;
                    end
                end
                ST_MEM: begin
                    st_reg <= ST_IDLE;
                    base_we_out <= wb_hold_reg && !data_abort_in;
                    base_out <= base_hold_reg;
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    property p_align;
        @(posedge core_clk_in) disable iff (!rstn_in)
        op_valid_in && is_dw && addr_in[2:0] == lsopt_pkg::DWORD_BAD_LOW
            |=> align_fault_out && !mem_req_out;
    endproperty
    a_align: assert property (p_align)
        else $error("Misaligned doubleword not trapped.");
    property p_dw_ok;
        @(posedge core_clk_in) disable iff (!rstn_in)
        op_valid_in && is_dw && addr_in[2:0] != lsopt_pkg::DWORD_BAD_LOW
            |=> !align_fault_out && mem_req_out;
    endproperty
    a_dw_ok: assert property (p_dw_ok)
        else $error("Aligned doubleword was refused.");
    property p_preload_dbg;
        @(posedge core_clk_in) disable iff (!rstn_in)
        op_valid_in && op == lsopt_pkg::OP_PRELOAD |=> !dbg_watch_out;
    endproperty
    a_preload_dbg: assert property (p_preload_dbg)
        else $error("Preload reached the breakpoint unit.");
    property p_preload_mmu;
        @(posedge core_clk_in) disable iff (!rstn_in)
        op_valid_in && op == lsopt_pkg::OP_PRELOAD |=> mmu_check_out && mem_read_out;
    endproperty
    a_preload_mmu: assert property (p_preload_mmu)
        else $error("Preload not checked as a read.");
    property p_preload_nc;
        @(posedge core_clk_in) disable iff (!rstn_in)
        op_valid_in && op == lsopt_pkg::OP_PRELOAD && !page_cacheable_in |=> !mem_req_out;
    endproperty
    a_preload_nc: assert property (p_preload_nc)
        else $error("Preload to non-cacheable page issued a request.");
    property p_preload_res;
        @(posedge core_clk_in) disable iff (!rstn_in)
        op_valid_in && op == lsopt_pkg::OP_PRELOAD && line_resident_in |=> !mem_req_out;
    endproperty
    a_preload_res: assert property (p_preload_res)
        else $error("Preload to resident line issued a request.");
    property p_cp;
        @(posedge core_clk_in) disable iff (!rstn_in)
        op_valid_in && is_cpd && cp_num_in != lsopt_pkg::DSP_CP_NUM
            |=> undef_out && !mem_req_out;
    endproperty
    a_cp: assert property (p_cp)
        else $error("Double transfer to other coprocessor not undefined.");
    property p_dsp;
        @(posedge core_clk_in) disable iff (!rstn_in)
        op_valid_in && is_cpd && !cp_access_in[lsopt_pkg::CPACC_DSP_BIT] |=> undef_out;
    endproperty
    a_dsp: assert property (p_dsp)
        else $error("DSP access with access bit clear not trapped.");
    property p_mode26;
        @(posedge core_clk_in) disable iff (!rstn_in)
        op_valid_in && op == lsopt_pkg::OP_MODE26
            |=> undef_out && !mem_req_out && !result_valid_out;
    endproperty
    a_mode26: assert property (p_mode26)
        else $error("Narrow address mode request was honoured.");
    property p_undef_quiet;
        @(posedge core_clk_in) disable iff (!rstn_in)
        undef_out |-> !mem_req_out && !result_valid_out && $stable(dsp_acc_out);
    endproperty
    a_undef_quiet: assert property (p_undef_quiet)
        else $error("Undefined operation changed state or issued traffic.");
    property p_acc_write;
        @(posedge core_clk_in) disable iff (!rstn_in)
        op_valid_in && op == lsopt_pkg::OP_CP_DWRITE && cp_num_in == lsopt_pkg::DSP_CP_NUM &&
            cp_access_in[lsopt_pkg::CPACC_DSP_BIT] |=> dsp_acc_out == $past(acc_in[39:0]);
    endproperty
    a_acc_write: assert property (p_acc_write)
        else $error("Accumulator write did not load the operand.");
    sequence s_abort_mem;
        st_reg == ST_MEM && data_abort_in;
    endsequence
    property p_abort;
        @(posedge core_clk_in) disable iff (!rstn_in)
        s_abort_mem |=> !base_we_out;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Base written despite data abort.");
    sequence s_mem_start;
        st_reg == ST_IDLE && op_valid_in && writeback_in &&
            (op == lsopt_pkg::OP_LOAD || op == lsopt_pkg::OP_STORE);
    endsequence
    property p_wb;
        @(posedge core_clk_in) disable iff (!rstn_in)
        s_mem_start ##1 !data_abort_in |=> base_we_out && base_out == $past(base_next_in, 2);
    endproperty
    a_wb: assert property (p_wb)
        else $error("Base not written after a clean access.");
    property p_endian;
        @(posedge core_clk_in) disable iff (!rstn_in)
        ##1 mem_big_endian_out == $past(ctrl_reg_in[lsopt_pkg::CTRL_ENDIAN_BIT]);
    endproperty
    a_endian: assert property (p_endian)
        else $error("Endian select does not follow the control bit.");
    property p_endian_mmu;
        @(posedge core_clk_in) disable iff (!rstn_in)
        !mmu_on_in |=> mem_big_endian_out == $past(ctrl_reg_in[lsopt_pkg::CTRL_ENDIAN_BIT]);
    endproperty
    a_endian_mmu: assert property (p_endian_mmu)
        else $error("Endian select ignored with translation off.");
    property p_lead_zeros;
        @(posedge core_clk_in) disable iff (!rstn_in)
        op_valid_in && op == lsopt_pkg::OP_LEAD_ZEROS && opa_in == 32'h0
            |=> result_out == 64'h20;
    endproperty
    a_lead_zeros: assert property (p_lead_zeros)
        else $error("Leading zero count of zero is not 32.");
endmodule

// ### common/lsopt_pkg.sv
// Purpose: Constants for the load/store and instruction-set option unit.
// Assumes: One core clock, synchronous active-low reset.
// Notes: Operation codes are local to the execute-stage interface.
// Operation
// - Endian select comes from control register bit 7.
// - Endian select applies whether translation is on or off.
// - No 26-bit addressing mode; only 32-bit addressing is used.
// - Compressed 16-bit instruction set is accepted alongside 32-bit.
// - Preload hint goes to the MMU as a read access.
// - Preload hints never raise data breakpoint events.
// - Preload hint to non-cacheable page does nothing, no external request.
// - Preload hint to resident line has no effect.
// - Doubleword load/store faults when address bits 2:0 equal 100.
// - Double coprocessor transfers allowed only to coprocessor zero.
// - Data abort with writeback leaves base register unchanged.
// - Signed 16x16 and 32x16 multiplies with optional 32/64-bit accumulate.
// - Saturating add/subtract clamp; doubling forms double-saturate one operand first.
// - Leading zero count of a register value.
// - DSP coprocessor access with access bit 0 clear is undefined.
// - Accumulator read sign-extends top byte; write loads bits 39:32.
package lsopt_pkg;
    localparam int CTRL_ENDIAN_BIT = 7;
    localparam int CPACC_DSP_BIT = 0;
    localparam logic [2:0] DWORD_BAD_LOW = 3'h4;
    localparam logic [3:0] DSP_CP_NUM = 4'h0;
    localparam int ACC_W = 40;
    localparam int ACC_HI_W = 8;
    localparam logic [31:0] SAT_MAX = 32'h7FFFFFFF;
    localparam logic [31:0] SAT_MIN = 32'h80000000;
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_LOAD = 5'h01,
        OP_STORE = 5'h02,
        OP_LOAD_DWORD = 5'h03,
        OP_STORE_DWORD = 5'h04,
        OP_PRELOAD = 5'h05,
        OP_CP_DWRITE = 5'h06,
        OP_CP_DREAD = 5'h07,
        OP_LEAD_ZEROS = 5'h08,
        OP_SAT_ADD = 5'h09,
        OP_SAT_SUB = 5'h0A,
        OP_DBL_SAT_ADD = 5'h0B,
        OP_DBL_SAT_SUB = 5'h0C,
        OP_HMUL = 5'h0D,
        OP_HMAC32 = 5'h0E,
        OP_HMAC64 = 5'h0F,
        OP_WHMUL = 5'h10,
        OP_WHMAC = 5'h11,
        OP_MODE26 = 5'h12
    } op_e;
endpackage

// ### test/tb_load_store_isa_options.sv
// Purpose: Self-checking bench for the execute-stage option unit.
// Assumes: Ops are driven on falling edges; results are read one falling edge later.
// Notes: Only the low word of 32-bit results is compared, since the upper half is unspecified.
`timescale 1ns/1ps
module tb_load_store_isa_options;
    logic core_clk_in = 1'b0, rstn_in = 1'b0, op_valid_in = 1'b0, isa16_in = 1'b0;
    logic x_top_in = 1'b0, y_top_in = 1'b0, writeback_in = 1'b0, mmu_on_in = 1'b1;
    logic page_cacheable_in = 1'b1, line_resident_in = 1'b0, data_abort_in = 1'b0;
    logic [4:0] op_code_in = 5'h00;
    logic [3:0] cp_num_in = 4'h0;
    logic [31:0] addr_in = 32'h0, base_next_in = 32'h0, opa_in = 32'h0, opb_in = 32'h0;
    logic [31:0] ctrl_reg_in = 32'h0, cp_access_in = 32'h1;
    logic [63:0] acc_in = 64'h0, result_out;
    logic mem_req_out, mem_read_out, mem_big_endian_out, mmu_check_out, dbg_watch_out;
    logic result_valid_out, q_flag_out, base_we_out, undef_out, align_fault_out, isa16_ok_out;
    logic [31:0] mem_addr_out, base_out;
    logic [39:0] dsp_acc_out;
    int fail_count = 0, samples_checked = 0, cycles = 0;

    load_store_isa_options DUT (.core_clk_in, .rstn_in, .op_valid_in, .op_code_in, .isa16_in,
        .cp_num_in, .x_top_in, .y_top_in, .writeback_in, .addr_in, .base_next_in, .opa_in,
        .opb_in, .acc_in, .ctrl_reg_in, .cp_access_in, .mmu_on_in, .page_cacheable_in,
        .line_resident_in, .data_abort_in, .mem_req_out, .mem_read_out, .mem_big_endian_out,
        .mem_addr_out, .mmu_check_out, .dbg_watch_out, .result_out, .result_valid_out,
        .q_flag_out, .base_we_out, .base_out, .undef_out, .align_fault_out, .dsp_acc_out,
        .isa16_ok_out);

    always #2 core_clk_in = ~core_clk_in;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One request is presented for one cycle; the task returns where its answer is settled.
    task automatic issue(input lsopt_pkg::op_e code);
        @(negedge core_clk_in);
        op_code_in = code;
        op_valid_in = 1'b1;
        @(negedge core_clk_in);
        op_valid_in = 1'b0;
    endtask

    task automatic t_endian();
        ctrl_reg_in = 32'h80;
        mmu_on_in = 1'b0;
        addr_in = 32'h1000;
        issue(lsopt_pkg::OP_LOAD);
        check(mem_big_endian_out, 1);
        check({mem_req_out, mem_read_out, dbg_watch_out}, 3'h7);
        mmu_on_in = 1'b1;
        ctrl_reg_in = 32'hFFFFFF7F;
        issue(lsopt_pkg::OP_STORE);
        check(mem_big_endian_out, 0);
        check({mem_req_out, mem_read_out}, 2'h2);
    endtask

    task automatic t_dword();
        addr_in = 32'h2004;
        issue(lsopt_pkg::OP_LOAD_DWORD);
        check({align_fault_out, mem_req_out}, 2'h2);
        addr_in = 32'h200C;
        issue(lsopt_pkg::OP_STORE_DWORD);
        check({align_fault_out, mem_req_out}, 2'h2);
        addr_in = 32'h2008;
        issue(lsopt_pkg::OP_STORE_DWORD);
        check({align_fault_out, mem_req_out}, 2'h1);
        check(mem_addr_out, 32'h2008);
    endtask

    task automatic t_preload();
        addr_in = 32'h3000;
        issue(lsopt_pkg::OP_PRELOAD);
        check({mem_req_out, mmu_check_out, mem_read_out, dbg_watch_out}, 4'hE);
        page_cacheable_in = 1'b0;
        issue(lsopt_pkg::OP_PRELOAD);
        check({mem_req_out, mmu_check_out, dbg_watch_out}, 3'h2);
        page_cacheable_in = 1'b1;
        line_resident_in = 1'b1;
        issue(lsopt_pkg::OP_PRELOAD);
        check({mem_req_out, dbg_watch_out}, 2'h0);
        line_resident_in = 1'b0;
    endtask

    task automatic t_coproc();
        acc_in = 64'h0000_00C5_1234_5678;
        issue(lsopt_pkg::OP_CP_DWRITE);
        check(dsp_acc_out, 40'hC512345678);
        issue(lsopt_pkg::OP_CP_DREAD);
        check(result_out, 64'hFFFF_FFC5_1234_5678);
        cp_num_in = 4'h1;
        issue(lsopt_pkg::OP_CP_DREAD);
        check({undef_out, mem_req_out}, 2'h2);
        cp_num_in = 4'h0;
        cp_access_in = 32'hFFFFFFFE;
        issue(lsopt_pkg::OP_CP_DWRITE);
        check({undef_out, mem_req_out}, 2'h2);
        check(dsp_acc_out, 40'hC512345678);
        cp_access_in = 32'h1;
        issue(lsopt_pkg::OP_MODE26);
        check({undef_out, mem_req_out}, 2'h2);
    endtask

    task automatic t_arith();
        opa_in = 32'h7FFFFFFF;
        opb_in = 32'h1;
        issue(lsopt_pkg::OP_SAT_ADD);
        check({q_flag_out, result_out[31:0]}, 33'h17FFFFFFF);
        opa_in = 32'h80000000;
        issue(lsopt_pkg::OP_SAT_SUB);
        check({q_flag_out, result_out[31:0]}, 33'h180000000);
        opa_in = 32'h40000000;
        opb_in = 32'h40000000;
        issue(lsopt_pkg::OP_DBL_SAT_ADD);
        check({q_flag_out, result_out[31:0]}, 33'h17FFFFFFF);
        opa_in = 32'h80000000;
        opb_in = 32'h80000000;
        issue(lsopt_pkg::OP_DBL_SAT_SUB);
        check({q_flag_out, result_out[31:0]}, 33'h100000000);
        opa_in = 32'h00010000;
        isa16_in = 1'b1;
        issue(lsopt_pkg::OP_LEAD_ZEROS);
        check(result_out[31:0], 32'hF);
        check(isa16_ok_out, 1);
        isa16_in = 1'b0;
        opa_in = 32'h0;
        issue(lsopt_pkg::OP_LEAD_ZEROS);
        check({result_valid_out, result_out[31:0]}, 33'h100000020);
    endtask

    task automatic t_mul();
        opa_in = 32'hFFFE0003;
        opb_in = 32'h00040005;
        x_top_in = 1'b1;
        issue(lsopt_pkg::OP_HMUL);
        check(result_out[31:0], 32'hFFFFFFF6);
        acc_in = 64'h64;
        issue(lsopt_pkg::OP_HMAC32);
        check(result_out[31:0], 32'h5A);
        acc_in = 64'h1_00000000;
        issue(lsopt_pkg::OP_HMAC64);
        check(result_out, 64'h0000_0000_FFFF_FFF6);
        x_top_in = 1'b0;
        opa_in = 32'h00020000;
        opb_in = 32'h00070003;
        issue(lsopt_pkg::OP_WHMUL);
        check(result_out[31:0], 32'h6);
        acc_in = 64'h1;
        y_top_in = 1'b1;
        issue(lsopt_pkg::OP_WHMAC);
        check(result_out[31:0], 32'hF);
        y_top_in = 1'b0;
    endtask

    task automatic t_abort();
        writeback_in = 1'b1;
        base_next_in = 32'h1234;
        issue(lsopt_pkg::OP_LOAD);
        data_abort_in = 1'b1;
        @(negedge core_clk_in);
        data_abort_in = 1'b0;
        check(base_we_out, 0);
        base_next_in = 32'h5678;
        issue(lsopt_pkg::OP_STORE);
        @(negedge core_clk_in);
        check({base_we_out, base_out}, 33'h100005678);
        writeback_in = 1'b0;
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // The whole run needs some seventy cycles; the ceiling leaves ample margin.
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (12) @(negedge core_clk_in);
        check({mem_req_out, undef_out, base_we_out}, 3'h0);
        rstn_in = 1'b1;
        t_endian();
        t_dword();
        t_preload();
        t_coproc();
        t_arith();
        t_mul();
        t_abort();
        report_and_stop();
    end
endmodule
